// ==== bench/i2cs_master.sv ====
// Purpose: bus master model that drives the serial register slave
// Assumes: open-drain data line resolved by the bench; the bus clock stands still outside frames
// Notes: every line change lands on a falling MCLK edge; one bit takes four quarters
`timescale 1ns/1ps
module i2cs_master #(
    parameter int QTR = 63
) (
    input  wire logic mclk,
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    int glitch; // data changes seen while the clock was high

    // both lines released while idle
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
        glitch = 0;
    end

    // a quarter bit of 63 cycles keeps the bus clock at or under 400 kHz
    task automatic qwait();
        repeat (QTR) @(negedge mclk);
    endtask

    // one bit: data changes only while the clock is low, sampled after the rise
    task automatic bit_xfer(input logic b, output logic s);
        logic s2;
        sda_oe = ~b;
        qwait();
        scl = 1'b1;
        qwait();
        s = sda;
        qwait();
        s2 = sda;
        scl = 1'b0;
        qwait();
        if (s2 !== s)
            glitch++;
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_oe = 1'b0;
        qwait();
        scl = 1'b1;
        qwait();
        sda_oe = 1'b1;
        qwait();
        scl = 1'b0;
        qwait();
    endtask

    // stop: data rises while the clock is high, then the bus is free
    task automatic stop();
        sda_oe = 1'b1;
        qwait();
        scl = 1'b1;
        qwait();
        sda_oe = 1'b0;
        qwait();
    endtask

    // send a byte msb first, release for the ninth bit and report the ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // take a byte; pull low on the ninth bit to ack, leave released to nack
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(~mack, s);
    endtask
endmodule

// ==== bench/i2cs_top_tb.sv ====
// Purpose: self-checking bench of the serial register slave
// Assumes: master model drives the bus; pull-up on the data line
// Notes: each scenario task drives and judges before it returns
`timescale 1ns/1ps
module i2cs_top_tb;
    logic mclk;        // system clock
    logic sys_rst;     // async reset
    logic wake_n;      // wake button, active low
    logic sda_o;       // device open-drain value
    logic sda_oe;      // device pulls data low
    logic power_off;   // off state flag
    logic scl;         // bus clock from the master model
    logic m_oe;        // master pulls data low
    wire  sda_line;    // resolved data line
    int   n_mismatch;  // failed comparisons
    int   check_count; // comparisons made

    // open-drain data line with a pull-up
    assign sda_line = ((sda_oe && !sda_o) || m_oe) ? 1'b0 : 1'b1;

    i2cs_top i2cs_top_inst (
        .MCLK          (mclk),
        .SYS_RST       (sys_rst),
        .SCL           (scl),
        .SDA_I         (sda_line),
        .SDA_O         (sda_o),
        .SDA_OE        (sda_oe),
        .WAKE_BUTTON_N (wake_n),
        .POWER_OFF     (power_off)
    );

    i2cs_master i2cs_master_inst (
        .mclk   (mclk),
        .scl    (scl),
        .sda_oe (m_oe),
        .sda    (sda_line)
    );

    // 100 MHz clock
    initial
        mclk = 1'b0;
    always #5 mclk = ~mclk;

    // flag comparison
    task automatic cmp1(input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // byte comparison
    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // start, write identifier and register address, both acked
    task automatic hdr(input logic [7:0] addr);
        logic a;
        i2cs_master_inst.start();
        i2cs_master_inst.wbyte(8'h54, a);
        cmp1(1'b1, a);
        i2cs_master_inst.wbyte(addr, a);
        cmp1(1'b1, a);
    endtask

    // write transaction, every data byte acked
    task automatic wr(input logic [7:0] addr, input logic [7:0] d[$]);
        logic a;
        hdr(addr);
        foreach (d[i])
        begin
            i2cs_master_inst.wbyte(d[i], a);
            cmp1(1'b1, a);
        end
        i2cs_master_inst.stop();
    endtask

    // read transaction: address, repeated start, bytes, nack on the last
    task automatic rd(input logic [7:0] addr, input logic [7:0] e[$]);
        logic       a;
        logic [7:0] v;
        hdr(addr);
        i2cs_master_inst.start();
        i2cs_master_inst.wbyte(8'h55, a);
        cmp1(1'b1, a);
        foreach (e[i])
        begin
            i2cs_master_inst.rbyte(i < e.size() - 1, v);
            cmp8(e[i], v);
        end
        i2cs_master_inst.stop();
        cmp1(1'b0, sda_oe);
    endtask

    // idle levels after reset
    task automatic t_reset();
        cmp1(1'b0, sda_oe);
        cmp1(1'b1, sda_line);
        cmp1(1'b0, sda_o);
        cmp1(1'b0, power_off);
        $display("test reset done");
    endtask

    // burst write, aborted write, burst read back
    task automatic t_burst();
        logic s;
        wr(8'h05, '{8'h11, 8'h22, 8'h33});
        hdr(8'h06);
        for (int i = 0; i < 4; i++)
            i2cs_master_inst.bit_xfer(1'b0, s);
        i2cs_master_inst.stop();
        rd(8'h05, '{8'h11, 8'h22, 8'h33});
        cmp8(8'h00, 8'(i2cs_master_inst.glitch));
        $display("test burst done");
    endtask

    // address 0x00 does not advance on write or read
    task automatic t_noinc();
        wr(8'h00, '{8'hA1, 8'hA2});
        rd(8'h00, '{8'hA2, 8'hA2});
        $display("test noinc done");
    endtask

    // foreign identifier and out-of-range register address
    task automatic t_refuse();
        logic a;
        i2cs_master_inst.start();
        i2cs_master_inst.wbyte(8'h56, a);
        cmp1(1'b0, a);
        i2cs_master_inst.stop();
        i2cs_master_inst.start();
        i2cs_master_inst.wbyte(8'h54, a);
        cmp1(1'b1, a);
        i2cs_master_inst.wbyte(8'h20, a);
        cmp1(1'b0, a);
        i2cs_master_inst.stop();
        $display("test refuse done");
    endtask

    // power-off command: wrong code, right code, bus ignored, wake pulse
    task automatic t_power();
        logic a;
        wr(8'h1F, '{8'h55});
        repeat (10) @(negedge mclk);
        cmp1(1'b0, power_off);
        wr(8'h1F, '{8'hB2});
        repeat (10) @(negedge mclk);
        cmp1(1'b1, power_off);
        i2cs_master_inst.start();
        i2cs_master_inst.wbyte(8'h54, a);
        cmp1(1'b0, a);
        i2cs_master_inst.stop();
        cmp1(1'b1, power_off);
        wake_n = 1'b0;
        repeat (10) @(negedge mclk);
        cmp1(1'b1, power_off);
        wake_n = 1'b1;
        repeat (10) @(negedge mclk);
        cmp1(1'b0, power_off);
        $display("test power done");
    endtask

    // counts, verdict, end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence: reset two cycles, settle, then the scenarios
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        sys_rst = 1'b1;
        wake_n = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_reset();
        t_burst();
        t_noinc();
        t_refuse();
        t_power();
        summarize();
    end

    // watchdog: the scenarios need about 80,000 cycles; give up at 100,000
    initial
    begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule

// ==== core/i2cs_top.sv ====
// Purpose: serial register slave with power-off command, plus its write FIFO
// Assumes: SCL at most 400 kHz against a 100 MHz MCLK; open-drain SDA resolved outside
// Notes: SDA_OE high pulls the line low; SDA_O always reads zero
`timescale 1ns/1ps
`include "i2cs_defs.svh"

// write queue between the bus side and the register file
module i2cs_fifo #(
    parameter int WIDTH = `I2CS_FIFO_WIDTH,
    parameter int DEPTH = `I2CS_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage words
        logic [AW-1:0]               wp;   // write pointer
        logic [AW-1:0]               rp;   // read pointer
        logic [AW:0]                 cnt;  // words held
    } fifo_t;

    fifo_t q, d;
    logic  do_wr;  // word accepted this cycle
    logic  do_rd;  // word taken this cycle

    assign in_ready  = (q.cnt != FULL);
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];

    // pointer and count update
    always_comb
    begin
        d     = q;
        do_wr = in_valid & in_ready;
        do_rd = out_valid & out_ready;
        if (do_wr)
        begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (do_rd)
        begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end
endmodule

module i2cs_top (
    input  wire logic MCLK,
    input  wire logic SYS_RST,
    input  wire logic SCL,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    input  wire logic WAKE_BUTTON_N,
    output logic      POWER_OFF
);
    i2cs_pkg::i2cs_link_t lk_q, lk_d;  // link domain state
    i2cs_pkg::i2cs_core_t q, d;        // system domain state
    logic                 rd_load;     // register file read port busy
    logic                 f_in_ready;  // queue has room
    logic                 f_out_valid; // queue holds a write
    logic [15:0]          f_out_data;  // {address, data}
    logic                 f_out_ready; // commit side takes it

    // queue drains unless a read fetch owns the register file
    assign f_out_ready = ~rd_load;

    i2cs_fifo #(
        .WIDTH(`I2CS_FIFO_WIDTH),
        .DEPTH(`I2CS_FIFO_DEPTH)
    ) u_wq (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .in_valid  (q.push),
        .in_ready  (f_in_ready),
        .in_data   (q.push_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // read-back value of a register; power-off slot is write-only
    function automatic logic [7:0] fetch(input i2cs_pkg::i2cs_core_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a != `I2CS_PWROFF_ADDR && a < `I2CS_REG_LIMIT)
            v = s.regs[a[4:0]];
        return v;
    endfunction

    // next address; register 0x00 holds still
    function automatic logic [7:0] advance(input logic [7:0] a);
        logic [7:0] v;
        v = a;
        if (a != `I2CS_ADDR_NOINC)
            v = a + 8'h01;
        return v;
    endfunction

    // link side: catch the data bit on each clock rise
    always_comb
    begin
        lk_d.sda_bit = SDA_I;
        lk_d.tog     = ~lk_q.tog;
    end

    always_ff @(posedge SCL or posedge SYS_RST)
    begin
        if (SYS_RST)
            lk_q <= '0;
        else
            lk_q <= lk_d;
    end

    // protocol engine and register file
    always_comb
    begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise    = 1'b0;
        fall    = 1'b0;
        start   = 1'b0;
        stop    = 1'b0;
        d       = q;
        rd_load = 1'b0;
        d.push  = 1'b0;
        // two-stage synchronisers, then one history stage
        d.scl_s1 = SCL;
        d.scl_s2 = q.scl_s1;
        d.scl_p  = q.scl_s2;
        d.sda_s1 = SDA_I;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        d.tog_s1 = lk_q.tog;
        d.tog_s2 = q.tog_s1;
        d.tog_p  = q.tog_s2;
        d.wk_s1  = WAKE_BUTTON_N;
        d.wk_s2  = q.wk_s1;
        d.wk_p   = q.wk_s2;
        rise  = q.tog_s2 != q.tog_p;
        fall  = q.scl_p & ~q.scl_s2;
        start = q.scl_s2 & q.sda_p & ~q.sda_s2;
        stop  = q.scl_s2 & ~q.sda_p & q.sda_s2;
        if (q.off)
        begin
            // sealed: bus ignored, lines released
            d.state = i2cs_pkg::ST_IDLE;
            d.oe    = 1'b0;
            if (!q.wk_p && q.wk_s2)
                d.off = 1'b0;
        end
        else if (start)
        begin
            // start or repeated start: fresh identifier byte
            d.state   = i2cs_pkg::ST_DEV;
            d.bit_cnt = 4'h0;
            d.oe      = 1'b0;
        end
        else if (stop)
        begin
            d.state = i2cs_pkg::ST_IDLE;
            d.oe    = 1'b0;
        end
        else
        begin
            unique case (q.state)
                i2cs_pkg::ST_IDLE:
                begin
                    d.oe = 1'b0;
                end
                i2cs_pkg::ST_DEV, i2cs_pkg::ST_REG, i2cs_pkg::ST_WDAT:
                begin
                    if (rise)
                    begin
                        d.shift   = {q.shift[6:0], lk_q.sda_bit};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                    else if (fall && q.bit_cnt == `I2CS_BYTE_BITS)
                    begin
                        d.bit_cnt = 4'h0;
                        if (q.state == i2cs_pkg::ST_DEV)
                        begin
                            if (q.shift[7:1] == `I2CS_SLAVE_ID)
                            begin
                                d.rw    = q.shift[0];
                                d.oe    = 1'b1;
                                d.state = i2cs_pkg::ST_ADEV;
                            end
                            else
                                d.state = i2cs_pkg::ST_IDLE;
                        end
                        else if (q.state == i2cs_pkg::ST_REG)
                        begin
                            d.ptr = q.shift;
                            if (q.shift < `I2CS_REG_LIMIT)
                            begin
                                d.oe    = 1'b1;
                                d.state = i2cs_pkg::ST_AREG;
                            end
                            else
                                d.state = i2cs_pkg::ST_IDLE;
                        end
                        else if (f_in_ready)
                        begin
                            d.push_data = {q.ptr, q.shift};
                            d.oe        = 1'b1;
                            d.state     = i2cs_pkg::ST_AWR;
                        end
                        else
                            d.state = i2cs_pkg::ST_IDLE;
                    end
                end
                i2cs_pkg::ST_ADEV:
                begin
                    if (fall)
                    begin
                        if (q.rw)
                        begin
                            // first read byte, msb on the line now
                            rd_load   = 1'b1;
                            d.shift   = fetch(q, q.ptr);
                            d.oe      = ~d.shift[7];
                            d.bit_cnt = 4'h0;
                            d.state   = i2cs_pkg::ST_RDAT;
                        end
                        else
                        begin
                            d.oe    = 1'b0;
                            d.state = i2cs_pkg::ST_REG;
                        end
                    end
                end
                i2cs_pkg::ST_AREG:
                begin
                    if (fall)
                    begin
                        d.oe    = 1'b0;
                        d.state = i2cs_pkg::ST_WDAT;
                    end
                end
                i2cs_pkg::ST_AWR:
                begin
                    if (fall)
                    begin
                        d.push  = 1'b1;
                        d.ptr   = advance(q.ptr);
                        d.oe    = 1'b0;
                        d.state = i2cs_pkg::ST_WDAT;
                    end
                end
                i2cs_pkg::ST_RDAT:
                begin
                    if (rise)
                    begin
                        d.shift   = {q.shift[6:0], 1'b0};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                    else if (fall)
                    begin
                        if (q.bit_cnt == `I2CS_BYTE_BITS)
                        begin
                            d.oe    = 1'b0;
                            d.state = i2cs_pkg::ST_RACK;
                        end
                        else
                            d.oe = ~q.shift[7];
                    end
                end
                i2cs_pkg::ST_RACK:
                begin
                    if (rise)
                        d.rw = ~lk_q.sda_bit;
                    else if (fall)
                    begin
                        if (q.rw && lk_q.sda_bit == 1'b0)
                        begin
                            rd_load   = 1'b1;
                            d.ptr     = advance(q.ptr);
                            d.shift   = fetch(q, advance(q.ptr));
                            d.oe      = ~d.shift[7];
                            d.bit_cnt = 4'h0;
                            d.state   = i2cs_pkg::ST_RDAT;
                        end
                        else
                        begin
                            d.oe    = 1'b0;
                            d.state = i2cs_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
        // commit queued writes to the register file
        if (f_out_valid && !rd_load)
        begin
            if (f_out_data[15:8] == `I2CS_PWROFF_ADDR)
            begin
                // only the exact code acts; any other value is dropped unstored
                if (f_out_data[7:0] == `I2CS_PWROFF_CODE)
                    d.off = 1'b1;
            end
            else if (f_out_data[15:8] < `I2CS_REG_LIMIT)
                d.regs[f_out_data[12:8]] = f_out_data[7:0];
        end
    end

    // state register
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            // synchronisers start at the idle line and button levels, so no false edge follows reset
            q <= '{state: i2cs_pkg::ST_IDLE,
                   scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
                   wk_s1: 1'b1, wk_s2: 1'b1, wk_p: 1'b1,
                   default: '0};
        end
        else
            q <= d;
    end

    assign SDA_O     = q.sda_o;
    assign SDA_OE    = q.oe;
    assign POWER_OFF = q.off;

    // decoded events for the checks below
    logic rise_c;
    logic fall_c;
    logic start_c;
    logic stop_c;
    assign rise_c  = q.tog_s2 != q.tog_p;
    assign fall_c  = q.scl_p & ~q.scl_s2;
    assign start_c = q.scl_s2 & q.sda_p & ~q.sda_s2;
    assign stop_c  = q.scl_s2 & ~q.sda_p & q.sda_s2;

    chk_off_entry: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (f_out_valid && f_out_ready && f_out_data == {`I2CS_PWROFF_ADDR, `I2CS_PWROFF_CODE}) |=> POWER_OFF)
        else $error("power-off code did not power off");
    chk_off_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (q.off && !(!q.wk_p && q.wk_s2)) |=> (q.off && !SDA_OE))
        else $error("left off state without wake pulse");
    chk_bad_code: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (!q.off && f_out_valid && f_out_ready && f_out_data[15:8] == `I2CS_PWROFF_ADDR
         && f_out_data[7:0] != `I2CS_PWROFF_CODE) |=> !q.off)
        else $error("other power-off code had an effect");
    chk_id_match: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $rose(q.state == i2cs_pkg::ST_ADEV) |-> ($past(q.shift[7:1]) == `I2CS_SLAVE_ID && SDA_OE))
        else $error("identifier ack without match");
    chk_start_seen: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (!q.off && q.scl_s2 && q.sda_p && !q.sda_s2) |=> (q.state == i2cs_pkg::ST_DEV && q.bit_cnt == 4'h0))
        else $error("start not taken");
    chk_idle_free: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (q.state == i2cs_pkg::ST_IDLE) [*2] |-> !SDA_OE)
        else $error("data line driven while idle");
    chk_reg_nack: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (!q.off && q.state == i2cs_pkg::ST_REG && !rise_c && fall_c && q.bit_cnt == `I2CS_BYTE_BITS
         && q.shift >= `I2CS_REG_LIMIT && !start_c && !stop_c) |=> (!SDA_OE && q.state == i2cs_pkg::ST_IDLE))
        else $error("invalid register address acknowledged");
    chk_ptr_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (d.push && q.ptr == `I2CS_ADDR_NOINC) |=> (q.ptr == `I2CS_ADDR_NOINC))
        else $error("address 0x00 advanced");
    chk_push_after_ack: assert property (@(posedge MCLK) disable iff (SYS_RST)
        d.push |-> (q.state == i2cs_pkg::ST_AWR && SDA_OE && fall_c))
        else $error("write queued before ack completed");
endmodule

// ==== shared/i2cs_defs.svh ====
// Purpose: constants of the serial register slave with power-off command
// Assumes: included by bare name wherever a constant is needed
// Notes: every offset, code and count lives here as a macro
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH
`define I2CS_SLAVE_ID      7'h2A
`define I2CS_ADDR_NOINC    8'h00
`define I2CS_PWROFF_ADDR   8'h1F
`define I2CS_PWROFF_CODE   8'hB2
`define I2CS_REG_COUNT     32
`define I2CS_REG_LIMIT     8'h20
`define I2CS_BYTE_BITS     4'h8
`define I2CS_FIFO_DEPTH    16
`define I2CS_FIFO_WIDTH    16
`endif

// ==== shared/i2cs_pkg.sv ====
// Purpose: types of the serial register slave
// Assumes: i2cs_defs.svh on the include path
// Notes: state structs hold every flip-flop of a module
`include "i2cs_defs.svh"
package i2cs_pkg;
    // protocol phases, one-hot
    typedef enum logic [8:0] {
        ST_IDLE  = 9'b0_0000_0001,
        ST_DEV   = 9'b0_0000_0010,
        ST_ADEV  = 9'b0_0000_0100,
        ST_REG   = 9'b0_0000_1000,
        ST_AREG  = 9'b0_0001_0000,
        ST_WDAT  = 9'b0_0010_0000,
        ST_AWR   = 9'b0_0100_0000,
        ST_RDAT  = 9'b0_1000_0000,
        ST_RACK  = 9'b1_0000_0000
    } i2cs_state_t;

    // link clock domain state
    typedef struct packed {
        logic sda_bit;  // data bit caught on the clock rise
        logic tog;      // flips once per clock rise
    } i2cs_link_t;

    // system clock domain state
    typedef struct packed {
        i2cs_state_t                       state;
        logic [3:0]                        bit_cnt;
        logic [7:0]                        shift;
        logic [7:0]                        ptr;
        logic                              rw;
        logic                              oe;
        logic                              sda_o;
        logic                              off;
        logic                              push;
        logic [15:0]                       push_data;
        logic                              scl_s1, scl_s2, scl_p;
        logic                              sda_s1, sda_s2, sda_p;
        logic                              tog_s1, tog_s2, tog_p;
        logic                              wk_s1, wk_s2, wk_p;
        logic [`I2CS_REG_COUNT-1:0][7:0]   regs;
    } i2cs_core_t;
endpackage
